// ===== bsctap_top.sv
// How it works
// RULE1: sixteen-state controller, instruction register, data registers
// RULE2: no test reset pin; TMS sequence resets
// RULE3: bypass, sample/preload and extest behave standardly
// RULE4: scan option dedicates TMS, TCK, TDI, TDO
// RULE5: every pad has input, output, enable cells
// RULE6: non-pad pins carry only needed cells
// RULE7: configuration control pins have no cells
// RULE8: extest capture samples all pad cells
// RULE9: internal enable bit 0, output bit 1
// RULE10: update test cell is last bit
// RULE11: bypass is one flip-flop stage
// RULE12: two user instruction selects to user logic
// RULE13: user instruction routes user scan input out
// RULE14: data register shift clock exported
// RULE15: NAND of TCK and idle exported
// RULE16: configure and readback instructions exist
// RULE17: pad cells ordered input, output, enable
// RULE18: mode pins a, c input; b three
// RULE19: three-bit instruction decode table
// RULE20: TDO changes on falling edge, shifts only
// RULE21: five TMS highs reach reset, bypass selected

package bsctap_pkg;
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;
  localparam int INT_W = 2;
  localparam int PAD_W = 3;
  localparam int TAIL_W = 6;
  // Bit positions inside one pad segment
  localparam int PAD_IN = 0;
  localparam int PAD_OUT = 1;
  localparam int PAD_OE = 2;
  // Bit positions inside the internal segment
  localparam int INT_OE = 0;
  localparam int INT_OUT = 1;
  // Bit positions inside the tail segment
  localparam int MA_IN = 0;
  localparam int MB_IN = 1;
  localparam int MB_OUT = 2;
  localparam int MB_OE = 3;
  localparam int MC_IN = 4;
  localparam int UPD_BIT = 5;

  typedef enum logic [IR_W-1:0] {
    I_EXTEST = 3'h0,
    I_SAMPLE = 3'h1,
    I_USER1 = 3'h2,
    I_USER2 = 3'h3,
    I_READBACK = 3'h4,
    I_CONFIGURE = 3'h5,
    I_RESERVED = 3'h6,
    I_BYPASS = 3'h7
  } bsctap_instr_e;

  typedef enum logic [15:0] {
    S_TLR = 16'h0001,
    S_RTI = 16'h0002,
    S_SEL_DR = 16'h0004,
    S_CAP_DR = 16'h0008,
    S_SH_DR = 16'h0010,
    S_EX1_DR = 16'h0020,
    S_PA_DR = 16'h0040,
    S_EX2_DR = 16'h0080,
    S_UPD_DR = 16'h0100,
    S_SEL_IR = 16'h0200,
    S_CAP_IR = 16'h0400,
    S_SH_IR = 16'h0800,
    S_EX1_IR = 16'h1000,
    S_PA_IR = 16'h2000,
    S_EX2_IR = 16'h4000,
    S_UPD_IR = 16'h8000
  } bsctap_state_e;

  typedef struct packed {
    logic sel_one;
    logic sel_two;
    logic shift_clock;
    logic idle_clock;
  } bsctap_user_s;

  typedef struct packed {
    logic load_sel;
    logic readback_sel;
    logic shift_en;
    logic data;
  } bsctap_cfg_s;
endpackage : bsctap_pkg

`timescale 1ns/1ps
`default_nettype none

module bsctap_top #(
  parameter int NUM_PADS = 4
) (
  // System clock domain
  input wire logic clk,
  input wire logic rst,
  // Scan option and test port
  input wire logic scan_enable,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // General pads
  input wire logic [NUM_PADS-1:0] pad_in,
  input wire logic [NUM_PADS-1:0] core_out,
  input wire logic [NUM_PADS-1:0] core_oe_n,
  output logic [NUM_PADS-1:0] pad_out,
  output logic [NUM_PADS-1:0] pad_oe_n,
  // Mode pins
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_c,
  input wire logic mode_select_pin_b_in,
  input wire logic mode_b_core_out,
  input wire logic mode_b_core_oe_n,
  output logic mode_select_pin_b_out,
  output logic mode_select_pin_b_oe_n,
  // Internal test cells
  input wire logic int_cap_oe,
  input wire logic int_cap_out,
  output logic test_update_cell,
  // User logic
  input wire logic user_scan_in_one,
  input wire logic user_scan_in_two,
  output bsctap_pkg::bsctap_user_s user_o,
  // Configuration path
  input wire logic config_dout,
  input wire logic readback_data,
  output bsctap_pkg::bsctap_cfg_s cfg_o,
  // Status in the system domain
  output logic core_extest,
  output logic core_update_cell
);
  import bsctap_pkg::*;

  localparam int BR_W = INT_W + PAD_W * NUM_PADS + TAIL_W;

  initial begin
    if (NUM_PADS < 1) $error("bsctap_top: NUM_PADS must be at least 1");
  end

  bsctap_state_e state_q;
  bsctap_state_e state_d;
  logic [IR_W-1:0] ir_sh_q;
  bsctap_instr_e ir_q;
  logic byp_q;
  logic ext_q;
  logic en_s;
  logic rst_tck;
  logic [NUM_PADS-1:0] pad_in_s;
  logic [2:0] mode_in_s;
  logic cap_br;
  logic sh_br;
  logic upd_br;
  logic tdo_d;
  logic drck_en_q;
  logic rti_n_q;
  logic [INT_W-1:0] int_upd;
  logic [TAIL_W-1:0] tail_upd;
  logic [TAIL_W-1:0] tail_cap;
  logic [PAD_W-1:0] pad_upd [NUM_PADS];
  logic [NUM_PADS:0] chain;
  logic tail_so;
  logic int_so;
  logic br_sel;
  logic user_sel;

  // The scan option is a strap; while off the controller stays in reset
  bsctap_sync #(.W(1)) u_en_sync (
    .clk(tck),
    .rst(1'b0),
    .d(scan_enable),
    .q(en_s)
  );
  assign rst_tck = ~en_s; // [RULE4]

  bsctap_sync #(.W(NUM_PADS + 3)) u_pin_sync (
    .clk(tck),
    .rst(rst_tck),
    .d({mode_select_pin_c, mode_select_pin_b_in, mode_select_pin_a,
        pad_in}),
    .q({mode_in_s, pad_in_s})
  );

  // No test reset pin: the only reset is the strap or the TMS walk
  always_ff @(posedge tck) begin
    if (rst_tck) begin
      state_q <= S_TLR;
    end else begin
      state_q <= state_d; // [RULE1] [RULE2]
    end
  end

  always_comb begin
    case (state_q)
      S_TLR: state_d = tms ? S_TLR : S_RTI; // [RULE21]
      S_RTI: state_d = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: state_d = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: state_d = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: state_d = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: state_d = tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR: state_d = tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: state_d = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: state_d = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: state_d = tms ? S_TLR : S_CAP_IR;
      S_CAP_IR: state_d = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: state_d = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: state_d = tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR: state_d = tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: state_d = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: state_d = tms ? S_SEL_DR : S_RTI;
      default: state_d = S_TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      ir_sh_q <= '0;
    end else if (state_q == S_CAP_IR) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (state_q == S_SH_IR) begin
      ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (rst_tck || state_q == S_TLR) begin
      ir_q <= I_BYPASS; // [RULE21]
    end else if (state_q == S_UPD_IR) begin
      ir_q <= bsctap_instr_e'(ir_sh_q); // [RULE19]
    end
  end

  // Registered so the decode crosses to the system clock glitch-free
  always_ff @(posedge tck) begin
    if (rst_tck) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= (state_q == S_UPD_IR) ? (ir_sh_q == I_EXTEST)
             : (state_q == S_TLR) ? 1'b0 : ext_q;
    end
  end

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      byp_q <= 1'b0;
    end else if (state_q == S_CAP_DR) begin
      byp_q <= 1'b0;
    end else if (state_q == S_SH_DR) begin
      byp_q <= tdi; // [RULE11]
    end
  end

  assign br_sel = (ir_q == I_EXTEST) || (ir_q == I_SAMPLE); // [RULE3]
  assign user_sel = (ir_q == I_USER1) || (ir_q == I_USER2);
  assign cap_br = br_sel && (state_q == S_CAP_DR); // [RULE8]
  assign sh_br = br_sel && (state_q == S_SH_DR);
  assign upd_br = br_sel && (state_q == S_UPD_DR);

  // Boundary chain, bit 0 nearest TDO; TDI enters at the update cell
  bsctap_bcell #(.W(INT_W)) u_int (
    .tck(tck),
    .rst_tck(rst_tck),
    .cap_en(cap_br),
    .shift_en(sh_br),
    .upd_en(upd_br),
    .si(chain[0]),
    .so(int_so),
    .cap_d({int_cap_out, int_cap_oe}), // [RULE9]
    .upd_q(int_upd)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PADS; gi++) begin : g_pad
      logic [PAD_W-1:0] cap_d;
      assign cap_d[PAD_IN] = pad_in_s[gi]; // [RULE17]
      assign cap_d[PAD_OUT] = pad_out[gi];
      assign cap_d[PAD_OE] = pad_oe_n[gi];
      bsctap_bcell #(.W(PAD_W)) u_cell (
        .tck(tck),
        .rst_tck(rst_tck),
        .cap_en(cap_br),
        .shift_en(sh_br),
        .upd_en(upd_br),
        .si(chain[gi+1]),
        .so(chain[gi]),
        .cap_d(cap_d), // [RULE5]
        .upd_q(pad_upd[gi])
      );
      // Configure floats the pads; extest drives them from the cells.
      // One continuous assignment per bit, so each pad bit has one driver
      assign pad_out[gi] = (ir_q == I_EXTEST) ? pad_upd[gi][PAD_OUT]
                                              : core_out[gi]; // [RULE3]
      assign pad_oe_n[gi] = (ir_q == I_CONFIGURE) ? 1'b1
                          : (ir_q == I_EXTEST) ? pad_upd[gi][PAD_OE]
                          : core_oe_n[gi];
    end
  endgenerate

  // Config clock, reconfig request and done pins are left out entirely
  always_comb begin
    tail_cap = '0; // [RULE7]
    tail_cap[MA_IN] = mode_in_s[0]; // [RULE6] [RULE18]
    tail_cap[MB_IN] = mode_in_s[1];
    tail_cap[MB_OUT] = mode_select_pin_b_out;
    tail_cap[MB_OE] = mode_select_pin_b_oe_n;
    tail_cap[MC_IN] = mode_in_s[2];
    tail_cap[UPD_BIT] = tail_upd[UPD_BIT]; // [RULE10]
  end

  bsctap_bcell #(.W(TAIL_W)) u_tail (
    .tck(tck),
    .rst_tck(rst_tck),
    .cap_en(cap_br),
    .shift_en(sh_br),
    .upd_en(upd_br),
    .si(tdi),
    .so(tail_so),
    .cap_d(tail_cap),
    .upd_q(tail_upd)
  );
  assign chain[NUM_PADS] = tail_so;

  assign mode_select_pin_b_out = (ir_q == I_EXTEST) ? tail_upd[MB_OUT]
                                                    : mode_b_core_out;
  assign mode_select_pin_b_oe_n = (ir_q == I_CONFIGURE) ? 1'b1
                                : (ir_q == I_EXTEST) ? tail_upd[MB_OE]
                                : mode_b_core_oe_n;
  assign test_update_cell = tail_upd[UPD_BIT]; // [RULE10]

  // Serial output source per instruction
  always_comb begin
    if (state_q == S_SH_IR) begin
      tdo_d = ir_sh_q[0];
    end else begin
      case (ir_q)
        I_EXTEST, I_SAMPLE: tdo_d = int_so;
        I_USER1: tdo_d = user_scan_in_one; // [RULE13]
        I_USER2: tdo_d = user_scan_in_two; // [RULE13]
        I_READBACK: tdo_d = readback_data; // [RULE16]
        I_CONFIGURE: tdo_d = config_dout; // [RULE16]
        default: tdo_d = byp_q; // [RULE11]
      endcase
    end
  end

  // Falling-edge launch gives the far end a full half period of setup
  always_ff @(negedge tck) begin
    if (rst_tck) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= tdo_d; // [RULE20]
      tdo_oe_n <= ~((state_q == S_SH_IR) || (state_q == S_SH_DR));
    end
  end

  // Gate enables change while TCK is low, so the idle clock does not glitch; shift_clock pulses low when its gate closes
  always_ff @(negedge tck) begin
    if (rst_tck) begin
      drck_en_q <= 1'b0;
      rti_n_q <= 1'b1;
    end else begin
      drck_en_q <= user_sel &&
                   ((state_q == S_CAP_DR) || (state_q == S_SH_DR));
      rti_n_q <= (state_q != S_RTI);
    end
  end

  assign user_o.sel_one = (ir_q == I_USER1); // [RULE12]
  assign user_o.sel_two = (ir_q == I_USER2); // [RULE12]
  assign user_o.shift_clock = drck_en_q ? tck : 1'b1; // [RULE14]
  assign user_o.idle_clock = ~(tck & ~rti_n_q); // [RULE15]

  assign cfg_o.load_sel = (ir_q == I_CONFIGURE); // [RULE16]
  assign cfg_o.readback_sel = (ir_q == I_READBACK); // [RULE16]
  assign cfg_o.shift_en = (state_q == S_SH_DR) &&
                          ((ir_q == I_CONFIGURE) || (ir_q == I_READBACK));
  assign cfg_o.data = tdi;

  bsctap_sync #(.W(2)) u_core_sync (
    .clk(clk),
    .rst(rst),
    .d({tail_upd[UPD_BIT], ext_q}),
    .q({core_update_cell, core_extest})
  );
endmodule : bsctap_top

`default_nettype wire

// ===== bsctap_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop level synchroniser; the first stage feeds only the second
module bsctap_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels from another domain
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("bsctap_sync: W must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : bsctap_sync

`default_nettype wire

// ===== bsctap_bcell.sv
`timescale 1ns/1ps
`default_nettype none

// One segment of the boundary register: capture, shift toward bit 0,
// and a parallel update stage that holds the value driven to the pins
module bsctap_bcell #(
  parameter int W = 3
) (
  // Test clock and reset
  input wire logic tck,
  input wire logic rst_tck,
  // Controller strobes
  input wire logic cap_en,
  input wire logic shift_en,
  input wire logic upd_en,
  // Serial path
  input wire logic si,
  output logic so,
  // Parallel data
  input wire logic [W-1:0] cap_d,
  output logic [W-1:0] upd_q
);
  logic [W-1:0] sh_q;

  initial begin
    if (W < 2) $error("bsctap_bcell: W must be at least 2");
  end

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      sh_q <= '0;
    end else if (cap_en) begin
      sh_q <= cap_d;
    end else if (shift_en) begin
      sh_q <= {si, sh_q[W-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (rst_tck) begin
      upd_q <= '0;
    end else if (upd_en) begin
      upd_q <= sh_q;
    end
  end

  assign so = sh_q[0];
endmodule : bsctap_bcell

`default_nettype wire

// ===== bsctap_top_props.sv
`timescale 1ns/1ps
`default_nettype none

module bsctap_top_props #(
  parameter int NUM_PADS = 4
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  // Test port
  input wire logic scan_enable,
  input wire logic tdi,
  input wire logic tdo_oe_n,
  // Pads, user and status
  input wire logic [NUM_PADS-1:0] pad_oe_n,
  input wire bsctap_pkg::bsctap_user_s user_o,
  input wire bsctap_pkg::bsctap_cfg_s cfg_o,
  input wire logic core_extest,
  input wire logic core_update_cell
);
  import bsctap_pkg::*;

  a_oe_idle: assert property (@(posedge tck)
    !scan_enable [*5] |-> tdo_oe_n)
    else $error("tdo enabled while scan port is off");
  a_sel_excl: assert property (@(posedge clk) disable iff (rst)
    user_o.sel_one |-> !user_o.sel_two && !cfg_o.load_sel)
    else $error("two instruction selects at once");
  a_cfg_excl: assert property (@(posedge clk) disable iff (rst)
    cfg_o.load_sel |-> !cfg_o.readback_sel && !user_o.sel_two)
    else $error("configure decoded with another instruction");
  a_idle_nand: assert property (@(posedge clk) disable iff (rst)
    !tck |-> user_o.idle_clock)
    else $error("idle clock low while tck low");
  a_drck_idle: assert property (@(posedge clk) disable iff (rst)
    !user_o.sel_one && !user_o.sel_two |-> user_o.shift_clock)
    else $error("shift clock runs without user instruction");
  a_cfg_data: assert property (@(posedge clk) disable iff (rst)
    cfg_o.data == tdi)
    else $error("configuration data differs from tdi");
  a_cfg_shift: assert property (@(posedge clk) disable iff (rst)
    cfg_o.shift_en |-> cfg_o.load_sel || cfg_o.readback_sel)
    else $error("config shift outside config instructions");
  a_cfg_pads: assert property (@(posedge clk) disable iff (rst)
    cfg_o.load_sel |-> &pad_oe_n)
    else $error("pads driven during configure");
  a_rst_core: assert property (@(posedge clk)
    $fell(rst) |-> !core_extest && !core_update_cell ##1 !core_extest)
    else $error("status not clear after reset");
endmodule : bsctap_top_props

bind bsctap_top bsctap_top_props #(.NUM_PADS(NUM_PADS)) u_props (
  .clk(clk), .rst(rst), .tck(tck), .scan_enable(scan_enable), .tdi(tdi),
  .tdo_oe_n(tdo_oe_n), .pad_oe_n(pad_oe_n), .user_o(user_o), .cfg_o(cfg_o),
  .core_extest(core_extest), .core_update_cell(core_update_cell));

`default_nettype wire

// ===== bsctap_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none

// Test controller; TCK stands still between transfers
module bsctap_jtag_host (
  // Test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic slow;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    slow = 1'b0;
  end
  // Inputs change after the falling edge, tdo is taken at the rising one
  task automatic clk_bit(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #(slow ? 20 : 6) tck = 1'b1;
    o = tdo;
    #6 tck = 1'b0;
  endtask : clk_bit
  task automatic to_idle();
    logic o;
    repeat (5) clk_bit(1'b1, tdi, o);
    clk_bit(1'b0, tdi, o);
  endtask : to_idle
  task automatic shift(input logic ir, input int n, input logic [19:0] din,
    output logic [19:0] dout);
    logic o;
    dout = '0;
    clk_bit(1'b1, tdi, o);
    if (ir) begin
      clk_bit(1'b1, tdi, o);
    end
    clk_bit(1'b0, tdi, o);
    clk_bit(1'b0, tdi, o);
    for (int i = 0; i < n; i++) begin
      clk_bit(i == n - 1, din[i], o);
      dout[i] = o;
    end
    clk_bit(1'b1, tdi, o);
    clk_bit(1'b0, tdi, o);
    // Released line must not keep its last value
    tdi = ~tdi;
  endtask : shift
endmodule : bsctap_jtag_host

`default_nettype wire

// ===== boundary_scan_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_tb_top;
  import bsctap_pkg::*;
  typedef struct packed {
    logic [2:0] code;
    logic [3:0] sel;
    logic dr_chk;
    logic [3:0] dr;
  } bsctap_row_s;
  localparam logic [18:0] PA = 19'h56a35;
  localparam logic [18:0] PB = 19'h2953a;
  bsctap_row_s rows [8] = '{
    '{3'h0, 4'h0, 1'b0, 4'h0}, '{3'h1, 4'h0, 1'b0, 4'h0},
    '{3'h2, 4'h8, 1'b1, 4'hf}, '{3'h3, 4'h4, 1'b1, 4'h0},
    '{3'h4, 4'h1, 1'b1, 4'h0}, '{3'h5, 4'h2, 1'b1, 4'hf},
    '{3'h6, 4'h0, 1'b1, 4'h6}, '{3'h7, 4'h0, 1'b1, 4'h6}};
  logic clk, rst, scan_enable, tck, tms, tdi, tdo, tdo_oe_n, b_out, b_oe_n;
  logic upd, core_extest, core_update_cell;
  logic [18:0] pat;
  logic [3:0] pad_out, pad_oe_n;
  bsctap_user_s user_o;
  bsctap_cfg_s cfg_o;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  bsctap_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // User and config sources tied to distinct levels
  bsctap_top #(.NUM_PADS(4)) dut (.clk(clk), .rst(rst),
    .scan_enable(scan_enable), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .pad_in(pat[3:0]), .core_out(pat[7:4]),
    .core_oe_n(pat[11:8]), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .mode_select_pin_a(pat[12]), .mode_select_pin_b_in(pat[13]),
    .mode_select_pin_c(pat[14]), .mode_b_core_out(pat[15]),
    .mode_b_core_oe_n(pat[16]), .mode_select_pin_b_out(b_out),
    .mode_select_pin_b_oe_n(b_oe_n), .int_cap_oe(pat[17]),
    .int_cap_out(pat[18]), .test_update_cell(upd),
    .user_scan_in_one(1'b1), .user_scan_in_two(1'b0), .user_o(user_o),
    .config_dout(1'b1), .readback_data(1'b0), .cfg_o(cfg_o),
    .core_extest(core_extest), .core_update_cell(core_update_cell));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Expected boundary image: internal pair, pads, then mode tail
  function automatic logic [19:0] bvec(logic [18:0] p, logic [3:0] o,
    logic [3:0] e, logic [1:0] b, logic u);
    bvec = {u, p[14], b, p[13:12], 12'h0, p[18:17]};
    for (int k = 0; k < 4; k++) begin
      bvec[2+3*k +: 3] = {e[k], o[k], p[k]};
    end
  endfunction : bvec

  task automatic chk(input logic [19:0] got, input logic [19:0] want);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    logic [19:0] d;
    logic [19:0] q;
    logic o;
    rst = 1'b1;
    scan_enable = 1'b0;
    pat = PA;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    host.to_idle();
    chk(tdo_oe_n, 1'b1);
    @(posedge clk);
    scan_enable <= 1'b1;
    @(posedge clk);
    host.to_idle();
    chk(core_extest, 1'b0);
    host.slow = 1'b1;
    foreach (rows[r]) begin
      host.shift(1'b1, 3, {17'h0, rows[r].code}, q);
      chk(q[1:0], 2'b01);
      chk({user_o.sel_one, user_o.sel_two, cfg_o.load_sel,
        cfg_o.readback_sel}, rows[r].sel);
      if (rows[r].dr_chk) begin
        host.shift(1'b0, 4, 20'hb, q);
        chk(q[3:0], rows[r].dr);
      end
    end
    host.slow = 1'b0;
    // Abort a user scan in mid-shift with the TMS reset sequence
    host.shift(1'b1, 3, 20'h2, q);
    host.clk_bit(1'b1, 1'b0, o);
    repeat (3) host.clk_bit(1'b0, 1'b0, o);
    chk({tdo_oe_n, tdo}, 2'b01);
    host.to_idle();
    chk({tdo_oe_n, user_o.sel_one}, 2'b10);
    host.shift(1'b0, 4, 20'hb, q);
    chk(q[3:0], 4'h6);
    d = bvec(19'h0, 4'hc, 4'h6, 2'b10, 1'b1);
    host.shift(1'b1, 3, 20'h1, q);
    host.shift(1'b0, 20, d, q);
    chk(q, bvec(PA, PA[7:4], PA[11:8], PA[16:15], 1'b0));
    chk(upd, 1'b1);
    @(posedge clk);
    pat <= PB;
    repeat (2) host.clk_bit(1'b0, 1'b0, o);
    host.shift(1'b0, 20, d, q);
    chk(q, bvec(PB, PB[7:4], PB[11:8], PB[16:15], 1'b1));
    chk(pad_out, PB[7:4]);
    host.shift(1'b1, 3, 20'h0, q);
    chk({pad_out, pad_oe_n, b_oe_n, b_out}, 10'h31a);
    repeat (4) @(posedge clk);
    chk({core_extest, core_update_cell}, 2'b11);
    host.shift(1'b0, 20, d, q);
    chk(q, bvec(PB, 4'hc, 4'h6, 2'b10, 1'b1));
    end_of_test();
  end
endmodule : boundary_scan_tap_tb_top

`default_nettype wire
